// ===== rtl/split_timer_cfg.svh
// Purpose: Offsets, field positions and reset values of the split byte timer
// Assumes: Byte addressed register bus, one 32-bit word per register
// Notes: Definitions only
`ifndef SPLIT_TIMER_CFG_SVH
`define SPLIT_TIMER_CFG_SVH

`define ST_ADDR_W 5
`define ST_OFS_CONTROL 5'h00
`define ST_OFS_T0_LOW 5'h04
`define ST_OFS_T0_HIGH 5'h08
`define ST_OFS_T1_COUNT 5'h0C
`define ST_OFS_STATUS 5'h10
`define ST_OFS_CLEAR 5'h14
`define ST_OFS_ENABLE 5'h18
`define ST_OFS_PRESCALE 5'h1C

// Per timer config byte: timer 0 in bits 7:0, timer 1 in bits 15:8
`define ST_T0_CFG_LSB 0
`define ST_T1_CFG_LSB 8
`define ST_CFG_RUN 0
`define ST_CFG_EXT_SEL 1
`define ST_CFG_GATE 2
`define ST_CFG_PRESC 3
`define ST_CFG_MODE_LSB 4

// Status, clear and enable share one layout
`define ST_STAT_T0_OVF 0
`define ST_STAT_T1_OVF 1

`define ST_CONTROL_RESET 16'h0000
`define ST_COUNT_RESET 8'h00
`define ST_STATUS_RESET 2'h0
`define ST_ENABLE_RESET 2'h0
`define ST_PRESCALE_RESET 8'h0B

`endif

// ===== rtl/split_timer_pkg.sv
// Purpose: Types shared by the split byte timer files
// Assumes: Nothing
// Notes: Constants live in split_timer_cfg.svh
package split_timer_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_type;

	typedef enum logic [1:0] {
		MODE_13BIT = 2'h0,
		MODE_16BIT = 2'h1,
		MODE_RELOAD = 2'h2,
		MODE_SPLIT = 2'h3
	} timer_mode_type;

	typedef struct packed {
		timer_mode_type mode;
		logic presc_sel;
		logic gate;
		logic ext_sel;
		logic run;
	} timer_cfg_type;

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic ovf;
	} count_step_type;

endpackage

// ===== rtl/tick_divider.sv
// Purpose: Prescaled clock tick, one pulse every divisor+1 clocks
// Assumes: Divisor may change at any time
// Notes: A divisor change takes effect at once; a count at or above the new divisor wraps on the next clock
`timescale 1ns/1ns
module tick_divider #(
	parameter int WIDTH = 8
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] divisor_in,
	output logic tick_out
);

	logic [WIDTH-1:0] count_q;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_q <= '0;
			tick_out <= 1'b0;
		end else if (count_q >= divisor_in) begin
			count_q <= '0;
			tick_out <= 1'b1;
		end else begin
			count_q <= count_q + 1'b1;
			tick_out <= 1'b0;
		end
	end

endmodule

// ===== rtl/split_dual_byte_timer.sv
// Purpose: Timer 0 and timer 1 with timer 0 split into two byte timers
// Assumes: Pins synchronous to core_clk_in; Avalon-MM slave with waitrequest
// Notes: One wait state on every access
// Operation
// - Split mode makes timer 0 two independent 8-bit counters, low and high byte.
// - Low byte uses timer 0 run, source select, gate; sets timer 0 overflow flag.
// - Low byte counts system or prescaled clock, or external input, per source select.
// - High byte is timer only: system or prescaled clock, never external input.
// - High byte runs only while timer 1 run bit is set.
// - High byte overflow sets timer 1 overflow flag and its interrupt.
// - In split mode timer 1 takes no external clock, sets no flag, no interrupt.
// - In split mode timer 1 overflows still reach other peripherals.
// - In split mode timer 1 runs in modes 0, 1, 2 and stops in mode 3.
`timescale 1ns/1ns
`include "split_timer_cfg.svh"
module split_dual_byte_timer
	import split_timer_pkg::*;
#(
	parameter int PRESC_W = 8
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [`ST_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic t0_ext_count_in,
	input wire logic t0_gate_pin_in,
	input wire logic t1_ext_count_in,
	output logic irq_out,
	output logic t0_overflow_pulse_out,
	output logic t1_overflow_pulse_out
);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] be);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic timer_cfg_type decode_cfg(input logic [7:0] cfg_byte);
		timer_cfg_type c;
		c.run = cfg_byte[`ST_CFG_RUN];
		c.ext_sel = cfg_byte[`ST_CFG_EXT_SEL];
		c.gate = cfg_byte[`ST_CFG_GATE];
		c.presc_sel = cfg_byte[`ST_CFG_PRESC];
		c.mode = timer_mode_type'(cfg_byte[`ST_CFG_MODE_LSB +: 2]);
		return c;
	endfunction

	// One counting step of a timer pair; split mode advances the low byte only
	function automatic count_step_type timer_step(input logic [7:0] low,
		input logic [7:0] high, input timer_mode_type mode, input logic inc);
		count_step_type s;
		s.low = low;
		s.high = high;
		s.ovf = 1'b0;
		if (inc) begin
			case (mode)
				MODE_13BIT: begin
					s.low[4:0] = low[4:0] + 5'h01;
					if (low[4:0] == 5'h1F) begin
						s.high = high + 8'h01;
						s.ovf = (high == 8'hFF);
					end
				end
				MODE_16BIT: begin
					{s.high, s.low} = {high, low} + 16'h0001;
					s.ovf = ({high, low} == 16'hFFFF);
				end
				MODE_RELOAD: begin
					s.low = (low == 8'hFF) ? high : low + 8'h01;
					s.ovf = (low == 8'hFF);
				end
				default: begin
					s.low = low + 8'h01;
					s.ovf = (low == 8'hFF);
				end
			endcase
		end
		return s;
	endfunction

	bus_state_type bus_state_q;
	logic [15:0] control_q;
	logic [7:0] t0_low_count_q;
	logic [7:0] t0_high_count_q;
	logic [15:0] t1_count_q;
	logic [1:0] status_q;
	logic [1:0] status_d;
	logic [1:0] enable_q;
	logic [PRESC_W-1:0] prescale_q;
	logic t0_ext_prev_q;
	logic t1_ext_prev_q;
	logic presc_tick;

	timer_cfg_type t0_cfg;
	timer_cfg_type t1_cfg;
	logic split_mode;
	logic t0_ext_tick;
	logic t1_ext_tick;
	logic t0_clk_tick;
	logic t1_clk_tick;
	logic t0_inc;
	logic t0_high_inc;
	logic t0_high_ovf;
	logic t1_inc;
	count_step_type t0_step;
	count_step_type t1_step;
	logic t0_flag_evt;
	logic t1_flag_evt;
	logic access;
	logic wr_fire;
	logic [31:0] read_mux;
	logic [31:0] wr_ctrl;
	logic [31:0] wr_t1;
	logic [31:0] wr_clear;

	tick_divider #(
		.WIDTH(PRESC_W)
	) u_prescaler (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.divisor_in(prescale_q),
		.tick_out(presc_tick)
	);

	assign t0_cfg = decode_cfg(control_q[`ST_T0_CFG_LSB +: 8]);
	assign t1_cfg = decode_cfg(control_q[`ST_T1_CFG_LSB +: 8]);
	assign split_mode = (t0_cfg.mode == MODE_SPLIT);

	// Falling edge of the count pins; pins are already synchronous
	assign t0_ext_tick = t0_ext_prev_q & ~t0_ext_count_in;
	assign t1_ext_tick = t1_ext_prev_q & ~t1_ext_count_in;
	assign t0_clk_tick = t0_cfg.presc_sel ? presc_tick : 1'b1;
	assign t1_clk_tick = t1_cfg.presc_sel ? presc_tick : 1'b1;

	// Low byte, or whole timer 0 outside split mode
	assign t0_inc = t0_cfg.run & (~t0_cfg.gate | t0_gate_pin_in) &
		(t0_cfg.ext_sel ? t0_ext_tick : t0_clk_tick);
	assign t0_step = timer_step(t0_low_count_q, t0_high_count_q, t0_cfg.mode, t0_inc);

	// High byte borrows the timer 1 run bit and never sees the pin
	assign t0_high_inc = split_mode & t1_cfg.run & t0_clk_tick;
	assign t0_high_ovf = t0_high_inc & (t0_high_count_q == 8'hFF);

	// In split mode timer 1 is steered by its mode alone, internal clock only
	always_comb begin
		if (split_mode) begin
			t1_inc = (t1_cfg.mode != MODE_SPLIT) & t1_clk_tick;
		end else begin
			t1_inc = t1_cfg.run & (t1_cfg.mode != MODE_SPLIT) &
				(t1_cfg.ext_sel ? t1_ext_tick : t1_clk_tick);
		end
	end
	assign t1_step = timer_step(t1_count_q[7:0], t1_count_q[15:8], t1_cfg.mode, t1_inc);

	assign t0_flag_evt = t0_step.ovf;
	assign t1_flag_evt = split_mode ? t0_high_ovf : t1_step.ovf;

	// Bus: request taken in idle, answered one cycle later with waitrequest low
	assign access = (bus_state_q == BUS_ACK) & (avs_read_in | avs_write_in);
	assign wr_fire = access & avs_write_in;
	assign wr_ctrl = merge_bytes({16'h0000, control_q}, avs_writedata_in, avs_byteenable_in);
	assign wr_t1 = merge_bytes({16'h0000, t1_count_q}, avs_writedata_in, avs_byteenable_in);
	assign wr_clear = merge_bytes(32'h0000_0000, avs_writedata_in, avs_byteenable_in);

	always_comb begin
		case (avs_address_in)
			`ST_OFS_CONTROL: read_mux = {16'h0000, control_q};
			`ST_OFS_T0_LOW: read_mux = {24'h00_0000, t0_low_count_q};
			`ST_OFS_T0_HIGH: read_mux = {24'h00_0000, t0_high_count_q};
			`ST_OFS_T1_COUNT: read_mux = {16'h0000, t1_count_q};
			`ST_OFS_STATUS: read_mux = {30'h0000_0000, status_q};
			`ST_OFS_ENABLE: read_mux = {30'h0000_0000, enable_q};
			`ST_OFS_PRESCALE: read_mux = {{(32-PRESC_W){1'b0}}, prescale_q};
			default: read_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bus_state_q <= BUS_IDLE;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h0000_0000;
		end else begin
			case (bus_state_q)
				BUS_IDLE: begin
					if (avs_read_in | avs_write_in) begin
						bus_state_q <= BUS_ACK;
						avs_waitrequest_out <= 1'b0;
						if (avs_read_in) begin
							avs_readdata_out <= read_mux;
						end
					end
				end
				BUS_ACK: begin
					bus_state_q <= BUS_IDLE;
					avs_waitrequest_out <= 1'b1;
				end
				default: begin
					bus_state_q <= BUS_IDLE;
					avs_waitrequest_out <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			control_q <= `ST_CONTROL_RESET;
			enable_q <= `ST_ENABLE_RESET;
			prescale_q <= PRESC_W'(`ST_PRESCALE_RESET);
		end else if (wr_fire) begin
			if (avs_address_in == `ST_OFS_CONTROL) begin
				control_q <= wr_ctrl[15:0];
			end
			if (avs_address_in == `ST_OFS_ENABLE) begin
				enable_q <= avs_byteenable_in[0] ? avs_writedata_in[1:0] : enable_q;
			end
			if (avs_address_in == `ST_OFS_PRESCALE) begin
				prescale_q <= avs_byteenable_in[0] ? avs_writedata_in[PRESC_W-1:0] : prescale_q;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			t0_ext_prev_q <= 1'b0;
			t1_ext_prev_q <= 1'b0;
		end else begin
			t0_ext_prev_q <= t0_ext_count_in;
			t1_ext_prev_q <= t1_ext_count_in;
		end
	end

	// Software load wins over a count in the same cycle
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			t0_low_count_q <= `ST_COUNT_RESET;
			t0_high_count_q <= `ST_COUNT_RESET;
		end else begin
			if (wr_fire && avs_address_in == `ST_OFS_T0_LOW && avs_byteenable_in[0]) begin
				t0_low_count_q <= avs_writedata_in[7:0];
			end else begin
				t0_low_count_q <= t0_step.low;
			end
			if (wr_fire && avs_address_in == `ST_OFS_T0_HIGH && avs_byteenable_in[0]) begin
				t0_high_count_q <= avs_writedata_in[7:0];
			end else if (split_mode) begin
				t0_high_count_q <= t0_high_count_q + {7'h00, t0_high_inc};
			end else begin
				t0_high_count_q <= t0_step.high;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			t1_count_q <= {`ST_COUNT_RESET, `ST_COUNT_RESET};
		end else if (wr_fire && avs_address_in == `ST_OFS_T1_COUNT) begin
			t1_count_q <= wr_t1[15:0];
		end else begin
			t1_count_q <= {t1_step.high, t1_step.low};
		end
	end

	// Sticky flags; a new event beats a clear in the same cycle
	always_comb begin
		status_d = status_q;
		if (wr_fire && avs_address_in == `ST_OFS_CLEAR) begin
			status_d = status_q & ~wr_clear[1:0];
		end
		if (t0_flag_evt) begin
			status_d[`ST_STAT_T0_OVF] = 1'b1;
		end
		if (t1_flag_evt) begin
			status_d[`ST_STAT_T1_OVF] = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			status_q <= `ST_STATUS_RESET;
			irq_out <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_out <= |(status_d & enable_q);
		end
	end

	// Overflow strobes for other peripherals, timer 1 even in split mode
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			t0_overflow_pulse_out <= 1'b0;
			t1_overflow_pulse_out <= 1'b0;
		end else begin
			t0_overflow_pulse_out <= t0_flag_evt;
			t1_overflow_pulse_out <= t1_step.ovf;
		end
	end

endmodule

// ===== test/split_timer_monitor.sv
// Purpose: Port checker for the split byte timer
// Assumes: Full byte lanes on control and enable writes
// Notes: Shadows control and enable from the bus, bound below
`timescale 1ns/1ns
`include "split_timer_cfg.svh"
module split_timer_monitor (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [`ST_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic irq_out,
	input wire logic t0_overflow_pulse_out,
	input wire logic t1_overflow_pulse_out
);
	logic [15:0] ctl_q;
	logic [1:0] en_q;
	logic wr_done;
	assign wr_done = avs_write_in && !avs_waitrequest_out;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctl_q <= 16'h0000;
		end else if (wr_done && avs_address_in == `ST_OFS_CONTROL) begin
			ctl_q <= avs_writedata_in[15:0];
		end
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			en_q <= 2'h0;
		end else if (wr_done && avs_address_in == `ST_OFS_ENABLE) begin
			en_q <= avs_writedata_in[1:0];
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("request not answered next cycle");
	chk_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	chk_wait_idle: assert property (!(avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> avs_waitrequest_out) else $error("answer without request");
	chk_rdata_hold: assert property (!(avs_read_in && avs_waitrequest_out)
		|=> $stable(avs_readdata_out)) else $error("read data moved");
	// Reload mode with an all-ones reload value overflows every cycle, so it is left out
	chk_t0_pulse_one: assert property (t0_overflow_pulse_out && ctl_q[5:4] != 2'h2
		|=> !t0_overflow_pulse_out)
		else $error("t0 pulse longer than one cycle");
	chk_t0_needs_run: assert property (t0_overflow_pulse_out
		|-> $past(ctl_q[0], 1) || $past(ctl_q[0], 2)) else $error("t0 overflow while stopped");
	chk_t0_irq_set: assert property (t0_overflow_pulse_out && en_q[0] |-> irq_out)
		else $error("t0 overflow raised no interrupt");
	chk_split_no_flag: assert property (en_q == 2'b10 && $stable(en_q) && !ctl_q[8]
		&& ctl_q[5:4] == 2'h3 && !irq_out |=> !irq_out) else $error("timer 1 flag in split");
	chk_irq_clear: assert property ($fell(irq_out) |-> $past(avs_write_in))
		else $error("interrupt dropped without a write");
	cover property (t0_overflow_pulse_out);
	cover property (t1_overflow_pulse_out);
	cover property ($rose(irq_out));
endmodule
bind split_dual_byte_timer split_timer_monitor mon_u (.core_clk_in, .rst_in, .avs_address_in,
	.avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
	.irq_out, .t0_overflow_pulse_out, .t1_overflow_pulse_out);

// ===== test/count_pin_model.sv
// Purpose: External count source driving the timer 0 count pin
// Assumes: Pin sampled on core_clk_in
// Notes: Each level lasts phase_in+1 clocks, so slow and fast sources both occur
`timescale 1ns/1ns
module count_pin_model (
	input wire logic core_clk_in,
	input wire logic go_in,
	input wire logic [7:0] falls_in,
	input wire logic [1:0] phase_in,
	output logic pin_out,
	output logic busy_out
);
	int left = 0;
	int dwell = 0;
	logic level_q = 1'b0;
	assign pin_out = level_q;
	assign busy_out = left != 0;
	always @(posedge core_clk_in) begin
		if (go_in && left == 0) begin
			left <= 2 * falls_in;
			dwell <= 0;
		end else if (left != 0 && dwell >= phase_in) begin
			// Ends low, so the last toggle is a falling edge
			level_q <= ~level_q;
			left <= left - 1;
			dwell <= 0;
		end else if (left != 0) begin
			dwell <= dwell + 1;
		end
	end
endmodule

// ===== test/split_dual_byte_timer_tb_top.sv
// Purpose: Self-checking bench of the split byte timer
// Assumes: One wait state per bus access
// Notes: Seeded random start values, prescale and pulse counts
`timescale 1ns/1ns
`include "split_timer_cfg.svh"
module split_dual_byte_timer_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [`ST_ADDR_W-1:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic wait_req, irq, t0_pulse, t1_pulse, ext_pin, ext_busy;
	logic gate_pin = 1'b0;
	logic t1_pin = 1'b0;
	logic go = 1'b0;
	logic [7:0] falls = 8'h00;
	logic [1:0] phase = 2'h0;
	logic [31:0] q, p, v;
	int seed = 84;
	int error_cnt = 0;
	int check_count = 0;
	int n;
	split_dual_byte_timer dut_u (.core_clk_in(clk), .rst_in(rst), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .t0_ext_count_in(ext_pin),
		.t0_gate_pin_in(gate_pin), .t1_ext_count_in(t1_pin), .irq_out(irq),
		.t0_overflow_pulse_out(t0_pulse), .t1_overflow_pulse_out(t1_pulse));
	count_pin_model src_u (.core_clk_in(clk), .go_in(go), .falls_in(falls), .phase_in(phase),
		.pin_out(ext_pin), .busy_out(ext_busy));
	initial forever #50 clk = ~clk;
	// Timer 1 pin keeps toggling; split mode must never count it
	always @(posedge clk) t1_pin <= ~t1_pin;
	function automatic logic [31:0] ctl(input logic [7:0] c1, input logic [7:0] c0);
		return {16'h0000, c1, c0};
	endfunction
	function automatic logic [31:0] add8(input logic [7:0] s, input logic [7:0] k);
		return {24'h00_0000, s + k};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
		n = 0;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wait_req !== 1'b0 && n < 40) begin
			@(posedge clk);
			n++;
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		chk("answer", 1, n < 40);
		@(posedge clk);
	endtask
	task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask
	task automatic wait_hi(input int sel, input int lim);
		n = 0;
		while ((sel == 0 ? t0_pulse : sel == 1 ? t1_pulse : irq) !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk("event", 1, n < lim);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#(100 * 20000);
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk("control", `ST_OFS_CONTROL, 32'h0000_0000);
		rd_chk("prescale", `ST_OFS_PRESCALE, 32'h0000_000B);
		xfer(1'b1, `ST_OFS_STATUS, 32'h0000_0003);
		rd_chk("status ro", `ST_OFS_STATUS, 32'h0000_0000);
		rd_chk("unmapped", 5'h02, 32'h0000_0000);
		v = $random(seed);
		xfer(1'b1, `ST_OFS_T0_HIGH, {24'h00_0000, v[7:0]});
		xfer(1'b1, `ST_OFS_T0_LOW, 32'h0000_00FC);
		xfer(1'b1, `ST_OFS_ENABLE, 32'h0000_0003);
		xfer(1'b1, `ST_OFS_CONTROL, ctl(8'h00, 8'h31));
		wait_hi(0, 20);
		chk("irq t0", 1, irq);
		rd_chk("low wrapped", `ST_OFS_T0_LOW, 32'h0000_0001);
		rd_chk("status t0", `ST_OFS_STATUS, 32'h0000_0001);
		rd_chk("high idle", `ST_OFS_T0_HIGH, {24'h00_0000, v[7:0]});
		xfer(1'b1, `ST_OFS_CONTROL, ctl(8'h00, 8'h30));
		xfer(1'b1, `ST_OFS_CLEAR, 32'h0000_0003);
		chk("irq clear", 0, irq);
		xfer(1'b0, `ST_OFS_T0_LOW, 32'h0000_0000);
		v = q;
		// Prescaled high byte: sixteen ticks must pass before it overflows
		p = $random(seed);
		xfer(1'b1, `ST_OFS_PRESCALE, {30'h0000_0000, p[1:0]});
		xfer(1'b1, `ST_OFS_T0_HIGH, 32'h0000_00F0);
		xfer(1'b1, `ST_OFS_CONTROL, ctl(8'h01, 8'h38));
		repeat (15 * (p[1:0] + 1) - 3) @(posedge clk);
		chk("early", 0, irq);
		wait_hi(2, 200);
		rd_chk("status t1", `ST_OFS_STATUS, 32'h0000_0002);
		rd_chk("low held", `ST_OFS_T0_LOW, v);
		xfer(1'b1, `ST_OFS_CONTROL, ctl(8'h00, 8'h30));
		xfer(1'b1, `ST_OFS_CLEAR, 32'h0000_0003);
		xfer(1'b1, `ST_OFS_ENABLE, 32'h0000_0002);
		xfer(1'b1, `ST_OFS_T1_COUNT, 32'h0000_FFFA);
		xfer(1'b1, `ST_OFS_CONTROL, ctl(8'h12, 8'h30));
		wait_hi(1, 30);
		rd_chk("t1 no flag", `ST_OFS_STATUS, 32'h0000_0000);
		chk("t1 no irq", 0, irq);
		for (int m = 0; m < 4; m++) begin
			xfer(1'b1, `ST_OFS_CONTROL, ctl({2'b00, m[1:0], 4'h2}, 8'h30));
			xfer(1'b0, `ST_OFS_T1_COUNT, 32'h0000_0000);
			p = q;
			xfer(1'b0, `ST_OFS_T1_COUNT, 32'h0000_0000);
			chk("t1 runs", m != 3, q != p);
			if (m == 1) begin
				// Reads are taken three clocks apart; the toggling pin must not matter
				chk("t1 sys clock", 32'h0000_0003, {16'h0000, q[15:0] - p[15:0]});
			end
		end
		// Gate bit off, gate pin low, gate pin high
		for (int k = 0; k < 3; k++) begin
			p = $random(seed);
			gate_pin <= k[1];
			falls <= {3'b000, p[12:8]} + 8'h01;
			phase <= p[15:14];
			xfer(1'b1, `ST_OFS_T0_LOW, {24'h00_0000, p[7:0]});
			xfer(1'b1, `ST_OFS_CONTROL, ctl(8'h00, k == 0 ? 8'h33 : 8'h37));
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			@(posedge clk);
			n = 0;
			while (ext_busy === 1'b1 && n < 400) begin
				@(posedge clk);
				n++;
			end
			chk("pin done", 1, n < 400);
			repeat (3) @(posedge clk);
			rd_chk("ext count", `ST_OFS_T0_LOW, add8(p[7:0], k == 1 ? 8'h00 : falls));
		end
		complete_run();
	end
endmodule
